/* File: ces_regs.vh */
// Constants for the core exception sequencer.
// Function
// RULE1 - Opwords 0000 and 4AFC raise vector 4
// RULE2 - Line-A gives vector 10, line-F 11
// RULE3 - Extension words and other opcodes unchecked
// RULE4 - Supervisor instruction in user mode: vector 8
// RULE5 - Trace bit set: vector 9 per instruction
// RULE6 - Stop waits for unmasked interrupt, no trace
// RULE7 - No stacking; trace during exception dropped
// RULE8 - Breakpoint gives vector 12, no acknowledge
// RULE9 - Bad return frame format raises vector 14
// RULE10 - Valid frame: status, PC, adjust SP, jump
// RULE11 - Trap always forces an exception
// RULE12 - Interrupt takes an 8-bit supplied vector
// RULE13 - Fault during fault processing halts forever
// RULE14 - Reset is vector 0, highest priority
// RULE15 - Reset sets S, mask 7, clears T, M
// RULE16 - Reset fetches SP at 0, PC at 4
// RULE17 - Fault before first instruction halts
// RULE18 - Stores busy two cycles after final store
// RULE19 - Aligned: word even, long modulo four
// RULE20 - Misaligned operands split into aligned accesses
// RULE21 - Misaligned accesses add cycles and accesses
// RULE22 - Frame format 4 to 7 from SP bits
// RULE23 - Trap 0 to 15 selects vectors 32-47
// RULE24 - Handler address is base plus four times vector
`ifndef CES_REGS_VH
`define CES_REGS_VH
`define CES_VEC_RESET 8'h00
`define CES_VEC_ACCESS 8'h02
`define CES_VEC_ILLEGAL 8'h04
`define CES_VEC_PRIV 8'h08
`define CES_VEC_TRACE 8'h09
`define CES_VEC_LINE_A 8'h0A
`define CES_VEC_LINE_F 8'h0B
`define CES_VEC_DEBUG 8'h0C
`define CES_VEC_FORMAT 8'h0E
`define CES_VEC_TRAP0 8'h20
`define CES_OP_ZERO 16'h0000
`define CES_OP_ILLEGAL 16'h4AFC
`define CES_SR_T 15
`define CES_SR_S 13
`define CES_SR_M 12
`define CES_SR_MASK 10:8
`define CES_FRAME_FMT 31:28
`define CES_SR_RESET 16'h2700
`define CES_VBR_RESET 32'h00000000
`define CES_ADDR_SP 32'h00000000
`define CES_ADDR_PC 32'h00000004
`define CES_FMT_MIN 4'h4
`define CES_FMT_MAX 4'h7
`define CES_STORE_BUSY 2'h2
`define CES_SZ_BYTE 2'h0
`define CES_SZ_WORD 2'h1
`define CES_SZ_LONG 2'h2
`endif

/* File: ces_store_guard.v */
// Store-resource busy window that stalls a following store.
`include "ces_regs.vh"
module ces_store_guard (
  input wire sys_clk,
  input wire rst,
  input wire store_done,
  input wire store_is_multi,
  input wire store_req,
  output wire store_stall
);
  reg [1:0] busy_q;
  reg [1:0] busy_d;
  always @* begin
    busy_d = busy_q;
    if (store_done && !store_is_multi) begin
      busy_d = `CES_STORE_BUSY; // see RULE18
    end else if (busy_q != 2'h0) begin
      busy_d = busy_q - 2'h1;
    end
  end
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 2'h0;
    end else begin
      busy_q <= busy_d;
    end
  end
  assign store_stall = store_req && (busy_q != 2'h0); // see RULE18
endmodule // ces_store_guard

/* File: ces_align_split.v */
// Splits a misaligned operand into aligned local bus accesses.
`include "ces_regs.vh"
module ces_align_split (
  input wire [31:0] addr,
  input wire [1:0] size,
  input wire is_write,
  output reg misaligned,
  output reg [1:0] piece_count,
  output reg [5:0] piece_sizes,
  output reg [2:0] extra_cycles,
  output reg [1:0] extra_accesses
);
  always @* begin
    misaligned = 1'b0;
    piece_count = 2'h1;
    piece_sizes = {4'h0, size};
    extra_cycles = 3'h0;
    extra_accesses = 2'h0;
    if (size == `CES_SZ_WORD && addr[0]) begin
      misaligned = 1'b1; // see RULE19
      piece_count = 2'h2;
      piece_sizes = {2'h0, `CES_SZ_BYTE, `CES_SZ_BYTE}; // see RULE20
      extra_cycles = is_write ? 3'h1 : 3'h2; // see RULE21
      extra_accesses = 2'h1;
    end else if (size == `CES_SZ_LONG && addr[0]) begin
      misaligned = 1'b1; // see RULE19
      piece_count = 2'h3;
      piece_sizes = {`CES_SZ_BYTE, `CES_SZ_WORD, `CES_SZ_BYTE}; // see RULE20
      extra_cycles = is_write ? 3'h2 : 3'h3; // see RULE21
      extra_accesses = 2'h2;
    end else if (size == `CES_SZ_LONG && addr[1]) begin
      misaligned = 1'b1; // see RULE19
      piece_count = 2'h2;
      piece_sizes = {2'h0, `CES_SZ_WORD, `CES_SZ_WORD}; // see RULE20
      extra_cycles = is_write ? 3'h1 : 3'h2; // see RULE21
      extra_accesses = 2'h1;
    end
  end
endmodule // ces_align_split

/* File: ces_exception_sequencer.v */
// Exception recognition, vectoring, return checking and reset fetch.
`include "ces_regs.vh"
module ces_exception_sequencer (
  input wire sys_clk,
  input wire rst,
  input wire insn_valid,
  input wire [15:0] insn_opword,
  input wire insn_is_super_only,
  input wire insn_is_trap,
  input wire insn_is_stop,
  input wire insn_is_return,
  input wire insn_done,
  input wire breakpoint_hit,
  input wire irq_pending,
  input wire [2:0] irq_level,
  input wire [7:0] irq_vector,
  input wire irq_vector_valid,
  input wire [31:0] sp_in,
  input wire [31:0] vbr_write_data,
  input wire vbr_write,
  input wire bus_grant,
  input wire other_master,
  input wire bus_done,
  input wire bus_error,
  input wire [31:0] bus_rdata,
  input wire op_valid,
  input wire [31:0] op_addr,
  input wire [1:0] op_size,
  input wire op_write,
  input wire store_done,
  input wire store_is_multi,
  output reg bus_req,
  output reg [31:0] bus_addr,
  output reg irq_ack_req,
  output reg exc_take,
  output reg [7:0] exc_vector,
  output reg [31:0] exc_handler_addr,
  output reg [3:0] frame_format,
  output reg [15:0] status_word,
  output reg [31:0] vector_base,
  output reg [31:0] sp_out,
  output reg [31:0] pc_out,
  output reg pc_load,
  output reg memctl_enable,
  output reg halted,
  output reg stopped,
  output reg store_stall,
  output reg op_misaligned,
  output reg [1:0] op_pieces,
  output reg [5:0] op_piece_sizes,
  output reg [2:0] op_extra_cycles,
  output reg [1:0] op_extra_accesses
);
  localparam [7:0] ST_RST_SP = 8'h01;
  localparam [7:0] ST_RST_PC = 8'h02;
  localparam [7:0] ST_RUN = 8'h04;
  localparam [7:0] ST_VEC = 8'h08;
  localparam [7:0] ST_INTERRUPT_ACKNOWLEDGE_CYCLE = 8'h10;
  localparam [7:0] ST_RET_SR = 8'h20;
  localparam [7:0] ST_RET_PC = 8'h40;
  localparam [7:0] ST_HALT = 8'h80;

  reg [7:0] state_q;
  reg first_done_q;
  reg in_fault_q;
  reg [31:0] ret_sp_q;
  reg [3:0] ret_fmt_q;
  wire guard_stall;
  wire split_mis;
  wire [1:0] split_cnt;
  wire [5:0] split_sizes;
  wire [2:0] split_cyc;
  wire [1:0] split_acc;

  // Handler address: vector base plus four times the vector number.
  function [31:0] handler_of;
    input [31:0] base;
    input [7:0] vec;
    begin
      handler_of = base + {22'h0, vec, 2'b00}; // see RULE24
    end
  endfunction

  // Two-longword frame format from the low stack pointer bits.
  function [3:0] format_of;
    input [31:0] sp;
    begin
      format_of = `CES_FMT_MIN + {2'b00, sp[1:0]}; // see RULE22
    end
  endfunction

  ces_store_guard u_guard (
    .sys_clk(sys_clk),
    .rst(rst),
    .store_done(store_done),
    .store_is_multi(store_is_multi),
    .store_req(op_valid && op_write),
    .store_stall(guard_stall)
  );

  ces_align_split u_split (
    .addr(op_addr),
    .size(op_size),
    .is_write(op_write),
    .misaligned(split_mis),
    .piece_count(split_cnt),
    .piece_sizes(split_sizes),
    .extra_cycles(split_cyc),
    .extra_accesses(split_acc)
  );

  // Synchronous exception vector of the current instruction; zero when none.
  // Only the opword is decoded, so extension words are never checked.
  reg [7:0] sync_vec;
  reg sync_hit;
  always @* begin
    sync_vec = 8'h00;
    sync_hit = 1'b0;
    if (insn_valid) begin
      if (insn_opword == `CES_OP_ZERO || insn_opword == `CES_OP_ILLEGAL) begin
        sync_vec = `CES_VEC_ILLEGAL; // see RULE1, RULE3
        sync_hit = 1'b1;
      end else if (insn_opword[15:12] == 4'hA) begin
        sync_vec = `CES_VEC_LINE_A; // see RULE2
        sync_hit = 1'b1;
      end else if (insn_opword[15:12] == 4'hF) begin
        sync_vec = `CES_VEC_LINE_F; // see RULE2
        sync_hit = 1'b1;
      end else if (insn_is_super_only && !status_word[`CES_SR_S]) begin
        sync_vec = `CES_VEC_PRIV; // see RULE4
        sync_hit = 1'b1;
      end else if (insn_is_trap) begin
        sync_vec = `CES_VEC_TRAP0 + {4'h0, insn_opword[3:0]}; // see RULE11, RULE23
        sync_hit = 1'b1;
      end
    end
  end

  wire irq_unmasked = irq_pending && (irq_level > status_word[`CES_SR_MASK] || irq_level == 3'h7);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RST_SP; // see RULE14
      first_done_q <= 1'b0;
      in_fault_q <= 1'b0;
      ret_sp_q <= 32'h0;
      ret_fmt_q <= 4'h0;
      bus_req <= 1'b0;
      bus_addr <= `CES_ADDR_SP;
      irq_ack_req <= 1'b0;
      exc_take <= 1'b0;
      exc_vector <= `CES_VEC_RESET;
      exc_handler_addr <= 32'h0;
      frame_format <= 4'h0;
      status_word <= `CES_SR_RESET; // see RULE15
      vector_base <= `CES_VBR_RESET; // see RULE15
      sp_out <= 32'h0;
      pc_out <= 32'h0;
      pc_load <= 1'b0;
      memctl_enable <= 1'b0; // see RULE15
      halted <= 1'b0;
      stopped <= 1'b0;
      store_stall <= 1'b0;
      op_misaligned <= 1'b0;
      op_pieces <= 2'h0;
      op_piece_sizes <= 6'h0;
      op_extra_cycles <= 3'h0;
      op_extra_accesses <= 2'h0;
    end else begin
      exc_take <= 1'b0;
      pc_load <= 1'b0;
      store_stall <= guard_stall;
      op_misaligned <= op_valid && split_mis;
      op_pieces <= op_valid ? split_cnt : 2'h0;
      op_piece_sizes <= split_sizes;
      op_extra_cycles <= op_valid ? split_cyc : 3'h0;
      op_extra_accesses <= op_valid ? split_acc : 2'h0;
      if (vbr_write && status_word[`CES_SR_S]) begin
        vector_base <= vbr_write_data;
      end
      case (state_q)
        ST_RST_SP: begin
          bus_addr <= `CES_ADDR_SP;
          bus_req <= bus_grant && !other_master; // see RULE16
          if (bus_req && bus_error) begin
            state_q <= ST_HALT; // see RULE17
            bus_req <= 1'b0;
          end else if (bus_req && bus_done) begin
            sp_out <= bus_rdata; // see RULE16
            bus_addr <= `CES_ADDR_PC;
            bus_req <= 1'b1;
            state_q <= ST_RST_PC;
          end
        end
        ST_RST_PC: begin
          if (bus_error) begin
            state_q <= ST_HALT; // see RULE17
            bus_req <= 1'b0;
          end else if (bus_done) begin
            pc_out <= bus_rdata; // see RULE16
            pc_load <= 1'b1;
            bus_req <= 1'b0;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (bus_error && (!first_done_q || in_fault_q)) begin
            state_q <= ST_HALT; // see RULE13, RULE17
          end else if (bus_error) begin
            exc_vector <= `CES_VEC_ACCESS;
            in_fault_q <= 1'b1;
            frame_format <= format_of(sp_in);
            state_q <= ST_VEC;
          end else if (stopped) begin
            if (irq_unmasked) begin
              stopped <= 1'b0; // see RULE6
              irq_ack_req <= 1'b1;
              state_q <= ST_INTERRUPT_ACKNOWLEDGE_CYCLE;
            end
          end else if (breakpoint_hit) begin
            exc_vector <= `CES_VEC_DEBUG; // see RULE8
            frame_format <= format_of(sp_in);
            state_q <= ST_VEC;
          end else if (sync_hit) begin
            // A trace pending with this exception is dropped, and ST_VEC clears T.
            exc_vector <= sync_vec; // see RULE7
            in_fault_q <= !insn_is_trap;
            frame_format <= format_of(sp_in);
            state_q <= ST_VEC;
          end else if (insn_valid && insn_is_return) begin
            ret_sp_q <= sp_in;
            bus_addr <= sp_in;
            bus_req <= 1'b1;
            state_q <= ST_RET_SR;
          end else if (insn_valid && insn_is_stop) begin
            stopped <= 1'b1; // see RULE6
            first_done_q <= 1'b1;
          end else if (insn_done && status_word[`CES_SR_T]) begin
            exc_vector <= `CES_VEC_TRACE; // see RULE5
            first_done_q <= 1'b1;
            frame_format <= format_of(sp_in);
            state_q <= ST_VEC;
          end else if (irq_unmasked) begin
            irq_ack_req <= 1'b1; // see RULE12
            state_q <= ST_INTERRUPT_ACKNOWLEDGE_CYCLE;
          end else if (insn_done) begin
            first_done_q <= 1'b1;
          end
        end
        ST_INTERRUPT_ACKNOWLEDGE_CYCLE: begin
          if (irq_vector_valid) begin
            irq_ack_req <= 1'b0;
            exc_vector <= irq_vector; // see RULE12
            frame_format <= format_of(sp_in);
            state_q <= ST_VEC;
          end
        end
        ST_RET_SR: begin
          if (bus_error) begin
            state_q <= ST_HALT; // see RULE13
            bus_req <= 1'b0;
          end else if (bus_done) begin
            if (bus_rdata[`CES_FRAME_FMT] < `CES_FMT_MIN || bus_rdata[`CES_FRAME_FMT] > `CES_FMT_MAX) begin
              // The original frame is untouched; the new frame points at the return.
              bus_req <= 1'b0;
              exc_vector <= `CES_VEC_FORMAT; // see RULE9
              in_fault_q <= 1'b1;
              frame_format <= format_of(ret_sp_q);
              state_q <= ST_VEC;
            end else begin
              ret_fmt_q <= bus_rdata[`CES_FRAME_FMT];
              status_word <= bus_rdata[15:0]; // see RULE10
              bus_addr <= ret_sp_q + 32'h4;
              state_q <= ST_RET_PC;
            end
          end
        end
        ST_RET_PC: begin
          if (bus_error) begin
            state_q <= ST_HALT; // see RULE13
            bus_req <= 1'b0;
          end else if (bus_done) begin
            bus_req <= 1'b0;
            pc_out <= bus_rdata; // see RULE10
            pc_load <= 1'b1;
            sp_out <= ret_sp_q + 32'h4 + {28'h0, ret_fmt_q}; // see RULE10
            in_fault_q <= 1'b0;
            state_q <= ST_RUN;
          end
        end
        ST_VEC: begin
          exc_take <= 1'b1;
          exc_handler_addr <= handler_of(vector_base, exc_vector); // see RULE24
          status_word[`CES_SR_S] <= 1'b1;
          status_word[`CES_SR_T] <= 1'b0;
          state_q <= ST_RUN;
        end
        ST_HALT: begin
          halted <= 1'b1; // see RULE13
          bus_req <= 1'b0;
        end
        default: begin
          state_q <= ST_HALT;
        end
      endcase
    end
  end
endmodule // ces_exception_sequencer

/* File: ces_properties.sv */
// Port-level assertions for the exception sequencer.
`include "ces_regs.vh"
module ces_properties (
  input wire sys_clk,
  input wire rst,
  input wire [15:0] insn_opword,
  input wire insn_is_trap,
  input wire [7:0] irq_vector,
  input wire irq_vector_valid,
  input wire bus_done,
  input wire bus_error,
  input wire [31:0] bus_rdata,
  input wire store_done,
  input wire store_is_multi,
  input wire op_valid,
  input wire [31:0] op_addr,
  input wire [1:0] op_size,
  input wire bus_req,
  input wire [31:0] bus_addr,
  input wire irq_ack_req,
  input wire exc_take,
  input wire [7:0] exc_vector,
  input wire [31:0] exc_handler_addr,
  input wire [15:0] status_word,
  input wire [31:0] vector_base,
  input wire [31:0] sp_out,
  input wire pc_load,
  input wire memctl_enable,
  input wire halted,
  input wire store_stall,
  input wire op_misaligned,
  input wire [1:0] op_pieces,
  input wire [5:0] op_piece_sizes
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  reg fetch_q;
  wire plain_store = store_done && !store_is_multi;
  // The reset fetch phase lasts until the first jump.
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      fetch_q <= 1'b1;
    else if (pc_load)
      fetch_q <= 1'b0;
  end
  sequence s_vec_answer;
    irq_ack_req && irq_vector_valid;
  endsequence
  sequence s_taken_vec;
    exc_take && exc_vector == $past(irq_vector, 2);
  endsequence
  chk_reset_state: assert property (
    $fell(rst) |-> status_word == `CES_SR_RESET && vector_base == 32'h0 && !memctl_enable)
    else $error("status word or vector base wrong after reset");
  chk_sp_load: assert property (
    fetch_q && bus_req && bus_done && bus_addr == `CES_ADDR_SP |=> sp_out == $past(bus_rdata))
    else $error("stack pointer not loaded from address zero");
  chk_early_fault: assert property (fetch_q && bus_req && bus_error |-> ##[1:3] halted)
    else $error("fault during reset fetch did not halt");
  chk_halt_sticky: assert property (halted |=> halted)
    else $error("halt left without reset");
  chk_illegal_cause: assert property (
    exc_take && exc_vector == `CES_VEC_ILLEGAL |-> $past(insn_opword, 2) inside {16'h0000, 16'h4AFC})
    else $error("illegal vector without reserved opword");
  chk_trap_vector: assert property (
    exc_take && exc_vector[7:4] == 4'h2 |-> $past(insn_is_trap, 2) && $past(insn_opword[3:0], 2) == exc_vector[3:0])
    else $error("trap vector does not match operand");
  chk_handler_addr: assert property (
    exc_take |-> exc_handler_addr == vector_base + {22'h0, exc_vector, 2'h0})
    else $error("handler address wrong");
  chk_irq_vector: assert property (s_vec_answer |-> ##2 s_taken_vec)
    else $error("supplied vector not taken two cycles later");
  chk_store_window: assert property (
    store_stall |-> $past(plain_store) || $past(plain_store, 2) || $past(plain_store, 3))
    else $error("stall outside the store busy window");
  chk_split_long: assert property (
    op_valid && op_size == `CES_SZ_LONG && op_addr[1:0] == 2'h2
    |=> op_misaligned && op_pieces == 2'h2 && op_piece_sizes[3:0] == 4'h5)
    else $error("long at address bits 10 not split into two words");
endmodule // ces_properties

bind ces_exception_sequencer ces_properties u_chk (.sys_clk, .rst, .insn_opword, .insn_is_trap, .irq_vector,
  .irq_vector_valid, .bus_done, .bus_error, .bus_rdata, .store_done, .store_is_multi, .op_valid, .op_addr,
  .op_size, .bus_req, .bus_addr, .irq_ack_req, .exc_take, .exc_vector, .exc_handler_addr, .status_word,
  .vector_base, .sp_out, .pc_load, .memctl_enable, .halted, .store_stall, .op_misaligned, .op_pieces,
  .op_piece_sizes);

/* File: ces_bus_model.sv */
// Behavioural local bus memory and interrupt vector source.
module ces_bus_model (
  input logic sys_clk,
  input logic rst,
  input logic bus_req,
  input logic [31:0] bus_addr,
  input logic irq_ack_req,
  input logic fail,
  input logic [1:0] wait_n,
  input logic [31:0] frame_word,
  output logic bus_done,
  output logic bus_error,
  output logic [31:0] bus_rdata,
  output logic irq_vector_valid,
  output logic [7:0] irq_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  // Released data toggle every cycle so stale values are never taken as answers.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_done <= 1'b0;
      bus_error <= 1'b0;
      bus_rdata <= 32'h0;
      cnt <= 2'h0;
      irq_vector_valid <= 1'b0;
      irq_vector <= 8'h0;
    end else begin
      irq_vector_valid <= irq_ack_req && !irq_vector_valid;
      irq_vector <= (irq_ack_req && !irq_vector_valid) ? 8'h40 : ~irq_vector;
      bus_done <= 1'b0;
      bus_error <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_done && !bus_error) begin
        cnt <= cnt + 2'h1;
        if (cnt == wait_n) begin
          cnt <= 2'h0;
          bus_error <= fail;
          bus_done <= !fail;
          bus_rdata <= bus_addr == 32'h0 ? 32'h1000 : bus_addr == 32'h4 ? 32'h400 :
                       bus_addr[2] ? 32'h800 : frame_word;
        end
      end
    end
  end
endmodule // ces_bus_model

/* File: tb.sv */
// Self-checking testbench for the exception sequencer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, insn_valid = 1'b0, insn_is_super_only = 1'b0, insn_is_trap = 1'b0;
  logic insn_is_stop = 1'b0, insn_is_return = 1'b0, insn_done = 1'b0, breakpoint_hit = 1'b0, irq_pending = 1'b0;
  logic bus_grant = 1'b0, other_master = 1'b1, op_valid = 1'b0, op_write = 1'b0, store_done = 1'b0;
  logic store_is_multi = 1'b0, fail = 1'b0, vbr_write = 1'b0;
  logic [15:0] insn_opword = 16'h0;
  logic [2:0] irq_level = 3'h7;
  logic [1:0] op_size = 2'h0, wait_n = 2'h2;
  logic [31:0] op_addr = 32'h0, frame_word = 32'h0, sp_in = 32'h1000;
  logic [31:0] vbr_write_data = 32'h0, vbase = 32'h0, got_hnd;
  logic bus_done, bus_error, irq_vector_valid, bus_req, irq_ack_req, exc_take, pc_load, memctl_enable, halted;
  logic stopped, store_stall, op_misaligned;
  logic [7:0] irq_vector, exc_vector, got_vec;
  logic [31:0] bus_rdata, bus_addr, exc_handler_addr, vector_base, sp_out, pc_out;
  logic [3:0] frame_format, got_fmt;
  logic [15:0] status_word;
  logic [1:0] op_pieces, op_extra_accesses;
  logic [5:0] op_piece_sizes;
  logic [2:0] op_extra_cycles;
  int mismatches = 0, n_compared = 0, n_exc = 0, n_pcl = 0, n_ack = 0, n_stall = 0;
  wire [11:0] split_seen = {op_misaligned, op_pieces, op_piece_sizes[3:0], op_extra_cycles, op_extra_accesses};
  ces_exception_sequencer u_dut (.*);
  ces_bus_model u_bus (.*);
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (exc_take === 1'b1) begin
      got_vec <= exc_vector;
      got_hnd <= exc_handler_addr;
      got_fmt <= frame_format;
      n_exc <= n_exc + 1;
    end
    n_pcl <= n_pcl + (pc_load === 1'b1);
    n_ack <= n_ack + (irq_ack_req === 1'b1);
    n_stall <= n_stall + (store_stall === 1'b1);
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string nm);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic insn(input logic [15:0] op, input logic [4:0] q);
    @(posedge sys_clk);
    insn_valid <= 1'b1;
    insn_opword <= op;
    {insn_done, insn_is_super_only, insn_is_trap, insn_is_stop, insn_is_return} <= q;
    @(posedge sys_clk);
    insn_valid <= 1'b0;
    {insn_done, insn_is_super_only, insn_is_trap, insn_is_stop, insn_is_return} <= 5'h0;
  endtask
  task automatic expect_exc(input logic [7:0] vec);
    int k;
    k = n_exc;
    repeat (30) if (n_exc == k) @(posedge sys_clk);
    #1;
    chk(1, n_exc - k, "exception count");
    chk(vec, got_vec, "exception vector");
    chk(vbase + {vec, 2'h0}, got_hnd, "handler address");
    chk(4'h4 + sp_in[1:0], got_fmt, "frame format");
  endtask
  task automatic t_exc(input logic [15:0] op, input logic [4:0] q, input logic [7:0] vec);
    insn(op, q);
    expect_exc(vec);
  endtask
  task automatic do_reset(input logic f);
    int k;
    k = n_pcl;
    @(posedge sys_clk);
    rst <= 1'b1;
    fail <= f;
    bus_grant <= 1'b0;
    other_master <= 1'b1;
    tick(4);
    rst <= 1'b0;
    tick(3);
    #1;
    chk(0, bus_req, "request before grant");
    chk(16'h2700, status_word, "reset status");
    chk(0, vector_base, "reset base");
    chk(0, memctl_enable, "memory control");
    @(posedge sys_clk);
    bus_grant <= 1'b1;
    other_master <= 1'b0;
    tick(25);
    #1;
    chk(!f, n_pcl - k, "fetch jumps");
    if (f) begin
      tick(10);
      chk(1, halted, "halted");
    end else begin
      chk(32'h1000, sp_out, "reset sp");
      chk(32'h400, pc_out, "reset pc");
    end
  endtask
  task automatic ret(input logic [31:0] fw);
    int k;
    k = n_pcl;
    @(posedge sys_clk);
    frame_word <= fw;
    wait_n <= fw[29:28];
    insn(16'h4E73, 5'h01);
    repeat (30) if (n_pcl == k) @(posedge sys_clk);
    #1;
    chk(1, n_pcl - k, "return jump");
    chk(32'h800, pc_out, "return pc");
    chk(32'h1004 + fw[31:28], sp_out, "return sp");
    chk(fw[15:0], status_word, "return status");
  endtask
  task automatic t_opwords;
    logic [15:0] ops [6] = '{16'h0000, 16'h4AFC, 16'hA123, 16'hF200, 16'h4E40, 16'h4E4F};
    logic [7:0] vecs [6] = '{8'h04, 8'h04, 8'h0A, 8'h0B, 8'h20, 8'h2F};
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      sp_in <= {30'h400, i[1:0]};
      t_exc(ops[i], {2'h0, i > 3, 2'h0}, vecs[i]);
    end
  endtask
  task automatic t_debug_irq;
    int k;
    k = n_ack;
    @(posedge sys_clk);
    breakpoint_hit <= 1'b1;
    @(posedge sys_clk);
    breakpoint_hit <= 1'b0;
    expect_exc(8'h0C);
    chk(k, n_ack, "acknowledge on debug");
    insn(16'h4E72, 5'h02);
    tick(3);
    #1;
    chk(1, stopped, "stopped");
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    repeat (20) if (irq_ack_req !== 1'b1) @(posedge sys_clk);
    irq_pending <= 1'b0;
    expect_exc(8'h40);
    chk(0, stopped, "stop left");
  endtask
  task automatic t_store;
    int k;
    for (int m = 1; m >= 0; m--) begin
      k = n_stall;
      @(posedge sys_clk);
      store_done <= 1'b1;
      store_is_multi <= m[0];
      op_valid <= 1'b1;
      op_write <= 1'b1;
      @(posedge sys_clk);
      store_done <= 1'b0;
      tick(4);
      op_valid <= 1'b0;
      tick(4);
      chk(m[0] ? 0 : 2, n_stall - k, "store stall cycles");
    end
  endtask
  task automatic t_split;
    logic [1:0] a [5] = '{2'h1, 2'h1, 2'h3, 2'h2, 2'h0};
    logic [1:0] sz [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [11:0] e [4] = '{12'hC09, 12'hC05, 12'hE8E, 12'hCA5};
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_addr <= {30'h800, a[i]};
      op_size <= sz[i];
      op_write <= i[0];
      @(posedge sys_clk);
      #1;
      if (i < 4)
        chk(e[i], split_seen, "split");
      else
        chk(0, op_misaligned, "aligned");
    end
    @(posedge sys_clk);
    op_valid <= 1'b0;
  endtask
  // A bus error while a fault is still being handled must halt the core.
  task automatic t_fault_halt;
    @(posedge sys_clk);
    fail <= 1'b1;
    insn(16'h4E73, 5'h01);
    tick(10);
    #1;
    chk(1, halted, "fault on fault");
  endtask
  initial begin
    do_reset(1'b0);
    @(posedge sys_clk);
    vbr_write <= 1'b1;
    vbr_write_data <= 32'h0001_0000;
    vbase <= 32'h0001_0000;
    @(posedge sys_clk);
    vbr_write <= 1'b0;
    ret(32'h4000_0000);
    t_exc(16'h46FC, 5'h08, 8'h08);
    ret(32'h5000_A700);
    t_exc(16'h4E4F, 5'h14, 8'h2F);
    ret(32'h6000_A700);
    t_exc(16'h4E71, 5'h10, 8'h09);
    t_opwords;
    @(posedge sys_clk);
    frame_word <= 32'h3000_2700;
    sp_in <= 32'h1000;
    t_exc(16'h4E73, 5'h01, 8'h0E);
    t_debug_irq;
    t_store;
    t_split;
    t_fault_halt;
    do_reset(1'b1);
    final_report;
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
endmodule // tb
